// ---- common/prv_pkg.sv ----
package prv_pkg;
   localparam int CLK_NS = 10;
   // Servo-on to first pulse, more than 40 ms
   localparam int SRV_WAIT_US = 40000;
   localparam int SRV_WAIT_CYC = SRV_WAIT_US * 1000 / CLK_NS + 1;
   // Clear held longer than 200 us
   localparam int CLR_HOLD_US = 200;
   localparam int CLR_HOLD_CYC = CLR_HOLD_US * 1000 / CLK_NS + 1;
   // Extra noise filter window, longest time, rounds down
   localparam int FILT_NS = 500;
   localparam int FILT_CYC = FILT_NS / CLK_NS;
   // Least half periods: 500 kpps line driver, 200 kpps open collector
   localparam int LD_HALF_NS = 1000;
   localparam int OC_HALF_NS = 2500;
   localparam logic [15:0] LD_HALF_CYC = 16'((LD_HALF_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] OC_HALF_CYC = 16'((OC_HALF_NS + CLK_NS - 1) / CLK_NS);
   // Motor feedback: 32768 P/R, quadrupled
   localparam int FB_PPR = 32768;
   localparam int FB_MULT = 4;
   localparam int FB_CPR = FB_PPR * FB_MULT;
   localparam int GEAR_W = 16;
   localparam logic [15:0] GEAR_RST = 16'h0001;
   localparam int ERR_W = 32;
   localparam int ACC_W = 19;
   typedef enum logic [1:0] {PRV_SIGN = 2'h0, PRV_FWDREV = 2'h1, PRV_QUAD = 2'h2} prv_form_t;
   typedef enum logic [1:0] {PRV_X1 = 2'h0, PRV_X2 = 2'h1, PRV_X4 = 2'h2} prv_mult_t;
   // Host register map (byte addresses)
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_PERIOD = 4'h4;
   localparam logic [3:0] ADDR_COUNT = 4'h8;
   localparam logic [3:0] ADDR_STATUS = 4'hc;
   localparam int CTRL_SRV = 0;
   localparam int CTRL_CLR = 1;
   localparam int CTRL_DIR = 2;
   localparam int CTRL_OC = 3;
   localparam int CTRL_FORM = 4;
   localparam logic [5:0] CTRL_RST = 6'h00;
   localparam logic [15:0] PERIOD_RST = 16'h0064;
   typedef enum logic [2:0] {HS_OFF = 3'b001, HS_WAIT = 3'b010, HS_READY = 3'b100} prv_hstate_t;
endpackage

// ---- common/prv_link_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface prv_link_if;
   logic servoOn;
   logic refPulse;
   logic refSign;
   logic clearOffset;
   modport dev (input servoOn, input refPulse, input refSign, input clearOffset);
   modport host (output servoOn, output refPulse, output refSign, output clearOffset);
endinterface
`default_nettype wire

// ---- src/prv_ref_dev.sv ----
`timescale 1ns/1ns
`default_nettype none
module prv_ref_dev
   import prv_pkg::*;
#(
   parameter int SRV_WAIT = SRV_WAIT_CYC
)(
   input wire logic clk,
   input wire logic rst_b,
   prv_link_if.dev link,
   input wire logic [1:0] cfgForm,
   input wire logic [1:0] cfgMult,
   input wire logic cfgFilter,
   input wire logic [GEAR_W-1:0] gearNumIn,
   input wire logic [GEAR_W-1:0] gearDenIn,
   input wire logic fbStep,
   input wire logic fbRev,
   output logic signed [ERR_W-1:0] posError,
   output logic posLoopEn,
   output logic refReady
);
   logic [3:0] sync1_r;
   logic [3:0] sync2_r;
   logic [3:0] sync3_r;
   logic [3:0] clean_r;
   logic [3:0] prev_r;
   logic [6:0] stab_r [2];
   logic [31:0] srvCnt_r;
   logic gearLoaded_r;
   logic [GEAR_W-1:0] gearNum_r;
   logic [GEAR_W-1:0] gearDen_r;
   logic signed [ACC_W-1:0] acc_r;
   logic signed [ERR_W-1:0] err_r;
   logic loopEn_r;
   logic ready_r;

   wire logic [3:0] agree = ~(sync2_r ^ sync3_r);
   wire logic a = clean_r[0];
   wire logic b = clean_r[1];
   wire logic aRise = a & ~prev_r[0];
   wire logic bRise = b & ~prev_r[1];
   wire logic aEdge = a ^ prev_r[0];
   wire logic bEdge = b ^ prev_r[1];
   wire logic srvOn = clean_r[2];
   wire logic clearIn = clean_r[3];
   wire logic signStep = aRise;
   wire logic signUp = b;
   wire logic frStep = aRise ^ bRise;
   wire logic frUp = aRise;
   wire logic aUp = a ^ b;
   wire logic bUp = ~(a ^ b);
   wire logic q1Step = aRise;
   wire logic q2Step = aEdge;
   wire logic q4Step = aEdge ^ bEdge;
   wire logic q1Up = ~b;
   wire logic q4Up = aEdge ? aUp : bUp;
   wire logic qStep = (cfgMult == PRV_X4) ? q4Step : (cfgMult == PRV_X2) ? q2Step : q1Step;
   wire logic qUp = (cfgMult == PRV_X4) ? q4Up : (cfgMult == PRV_X2) ? aUp : q1Up;
   wire logic rawStep = (cfgForm == PRV_QUAD) ? qStep : (cfgForm == PRV_FWDREV) ? frStep : signStep;
   wire logic rawUp = (cfgForm == PRV_QUAD) ? qUp : (cfgForm == PRV_FWDREV) ? frUp : signUp;
   wire logic step = rawStep & ready_r & ~clearIn;
   wire logic srvDone = srvCnt_r >= 32'(SRV_WAIT);
   wire logic signed [ACC_W-1:0] numS = ACC_W'(gearNum_r);
   wire logic signed [ACC_W-1:0] denS = ACC_W'(gearDen_r);
   // Remainder drains one unit of denominator per count
   wire logic drainUp = acc_r >= denS;
   wire logic drainDn = acc_r <= -denS;
   wire logic signed [ACC_W-1:0] accAdd = step ? (rawUp ? numS : -numS) : '0;
   wire logic signed [ACC_W-1:0] accSub = drainUp ? denS : drainDn ? -denS : '0;
   wire logic signed [ERR_W-1:0] cmdInc = drainUp ? ERR_W'(1) : drainDn ? -ERR_W'(1) : '0;
   wire logic signed [ERR_W-1:0] fbInc = fbStep ? (fbRev ? -ERR_W'(1) : ERR_W'(1)) : '0;

   // Three stages; only stages two and three are compared
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         sync1_r <= 4'h0;
         sync2_r <= 4'h0;
         sync3_r <= 4'h0;
      end
      else
      begin
         sync1_r <= {link.clearOffset, link.servoOn, link.refSign, link.refPulse};
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   // Pulse lines need a stable window when filtered
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         stab_r[0] <= 7'h00;
         stab_r[1] <= 7'h00;
      end
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            if (!agree[i] || sync3_r[i] == clean_r[i])
               stab_r[i] <= 7'h00;
            else if (stab_r[i] != 7'h7f)
               stab_r[i] <= stab_r[i] + 7'h01;
         end
      end
   end

   // Unfiltered path follows within four cycles
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         clean_r <= 4'h0;
         prev_r <= 4'h0;
      end
      else
      begin
         prev_r <= clean_r;
         for (int i = 0; i < 4; i++)
         begin
            if (agree[i] && (i > 1 || !cfgFilter || stab_r[i % 2] >= 7'(FILT_CYC - 1)))
               clean_r[i] <= sync3_r[i];
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
         srvCnt_r <= 32'h0;
      else if (!srvOn)
         srvCnt_r <= 32'h0;
      else if (!srvDone)
         srvCnt_r <= srvCnt_r + 32'h1;
   end

   // Gear terms taken once after reset release
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         gearLoaded_r <= 1'b0;
         gearNum_r <= GEAR_RST;
         gearDen_r <= GEAR_RST;
      end
      else if (!gearLoaded_r)
      begin
         gearLoaded_r <= 1'b1;
         gearNum_r <= (gearNumIn == '0) ? GEAR_RST : gearNumIn;
         gearDen_r <= (gearDenIn == '0) ? GEAR_RST : gearDenIn;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         acc_r <= '0;
         err_r <= '0;
      end
      else if (clearIn || !gearLoaded_r)
      begin
         acc_r <= '0;
         err_r <= '0;
      end
      else
      begin
         acc_r <= acc_r + accAdd - accSub;
         err_r <= err_r + cmdInc - fbInc;
      end
   end

   // Loop disabled while clear is active
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         loopEn_r <= 1'b0;
         ready_r <= 1'b0;
      end
      else
      begin
         loopEn_r <= srvDone & srvOn & ~clearIn;
         ready_r <= srvDone & srvOn & gearLoaded_r;
      end
   end

   assign posError = err_r;
   assign posLoopEn = loopEn_r;
   assign refReady = ready_r;
endmodule
`default_nettype wire

// ---- src/prv_ref_host.sv ----
`timescale 1ns/1ns
`default_nettype none
module prv_ref_host
   import prv_pkg::*;
#(
   parameter int SRV_WAIT = SRV_WAIT_CYC,
   parameter int CLR_HOLD = CLR_HOLD_CYC
)(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   prv_link_if.host link
);
   prv_hstate_t state_r;
   logic [5:0] ctrl_r;
   logic [15:0] period_r;
   logic [31:0] remain_r;
   logic [31:0] waitCnt_r;
   logic [31:0] clrCnt_r;
   logic [15:0] halfCnt_r;
   logic [1:0] phase_r;
   logic wait_r;
   logic [31:0] rdata_r;
   logic srvOut_r;
   logic pulseOut_r;
   logic signOut_r;
   logic clrOut_r;

   wire logic wrTake = avs_write & ~wait_r;
   wire logic rdTake = avs_read & wait_r;
   wire logic wrCtrl = wrTake & (avs_address == ADDR_CTRL);
   wire logic wrPeriod = wrTake & (avs_address == ADDR_PERIOD);
   wire logic wrCount = wrTake & (avs_address == ADDR_COUNT);
   wire logic [1:0] form = ctrl_r[CTRL_FORM+:2];
   wire logic dir = ctrl_r[CTRL_DIR];
   wire logic clearing = clrCnt_r != 32'h0;
   // Open collector pulse rate never above 200 kpps
   wire logic [15:0] minHalf = ctrl_r[CTRL_OC] ? OC_HALF_CYC : LD_HALF_CYC;
   wire logic [15:0] half = (period_r < minHalf) ? minHalf : period_r;
   wire logic running = (state_r == HS_READY) & (remain_r != 32'h0) & ~clearing;
   wire logic tick = running & (halfCnt_r >= half - 16'h1);
   wire logic lastPhase = (form == PRV_QUAD) ? (phase_r == 2'h3) : (phase_r == 2'h1);
   wire logic [1:0] phaseNxt = lastPhase ? 2'h0 : phase_r + 2'h1;
   wire logic qa = phase_r[0] ^ phase_r[1];
   wire logic qb = phase_r[1];
   wire logic pulseNxt = (form == PRV_QUAD) ? (dir ? qa : qb) : (form == PRV_FWDREV) ? (phase_r[0] & dir) : phase_r[0];
   wire logic signNxt = (form == PRV_QUAD) ? (dir ? qb : qa) : (form == PRV_FWDREV) ? (phase_r[0] & ~dir) : dir;
   wire logic [31:0] status = {29'h0, remain_r != 32'h0, clearing, state_r == HS_READY};
   wire logic [31:0] rdSel = (avs_address == ADDR_CTRL) ? {26'h0, ctrl_r} :
      (avs_address == ADDR_PERIOD) ? {16'h0, period_r} :
      (avs_address == ADDR_COUNT) ? remain_r :
      (avs_address == ADDR_STATUS) ? status : 32'h0;

   // One wait cycle per access
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         wait_r <= 1'b1;
         rdata_r <= 32'h0;
      end
      else
      begin
         wait_r <= ~(wait_r & (avs_read | avs_write));
         if (rdTake)
            rdata_r <= rdSel;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         ctrl_r <= CTRL_RST;
         period_r <= PERIOD_RST;
      end
      else
      begin
         if (wrCtrl)
            ctrl_r <= {avs_writedata[CTRL_FORM+:2], avs_writedata[CTRL_OC:CTRL_DIR], 1'b0,
               avs_writedata[CTRL_SRV]};
         if (wrPeriod)
            period_r <= avs_writedata[15:0];
      end
   end

   // Pulses held back for the servo-on delay
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         state_r <= HS_OFF;
         waitCnt_r <= 32'h0;
      end
      else
      begin
         unique case (state_r)
            HS_OFF:
            begin
               waitCnt_r <= 32'h0;
               if (ctrl_r[CTRL_SRV])
                  state_r <= HS_WAIT;
            end
            HS_WAIT:
            begin
               waitCnt_r <= waitCnt_r + 32'h1;
               if (!ctrl_r[CTRL_SRV])
                  state_r <= HS_OFF;
               else if (waitCnt_r >= 32'(SRV_WAIT))
                  state_r <= HS_READY;
            end
            HS_READY:
               if (!ctrl_r[CTRL_SRV])
                  state_r <= HS_OFF;
            default:
               state_r <= HS_OFF;
         endcase
      end
   end

   // Clear held for the full hold time
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         clrCnt_r <= 32'h0;
      else if (wrCtrl && avs_writedata[CTRL_CLR])
         clrCnt_r <= 32'(CLR_HOLD);
      else if (clearing)
         clrCnt_r <= clrCnt_r - 32'h1;
   end

   // Direction changes on any control write, even mid-burst, so sign setup is not guaranteed
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         remain_r <= 32'h0;
         halfCnt_r <= 16'h0;
         phase_r <= 2'h0;
      end
      else if (wrCount)
      begin
         remain_r <= avs_writedata;
         halfCnt_r <= 16'h0;
         phase_r <= 2'h0;
      end
      else if (tick)
      begin
         halfCnt_r <= 16'h0;
         phase_r <= phaseNxt;
         if (lastPhase)
            remain_r <= remain_r - 32'h1;
      end
      else if (running)
         halfCnt_r <= halfCnt_r + 16'h1;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         srvOut_r <= 1'b0;
         pulseOut_r <= 1'b0;
         signOut_r <= 1'b0;
         clrOut_r <= 1'b0;
      end
      else
      begin
         srvOut_r <= ctrl_r[CTRL_SRV];
         pulseOut_r <= pulseNxt;
         signOut_r <= signNxt;
         clrOut_r <= clearing;
      end
   end

   assign avs_waitrequest = wait_r;
   assign avs_readdata = rdata_r;
   assign link.servoOn = srvOut_r;
   assign link.refPulse = pulseOut_r;
   assign link.refSign = signOut_r;
   assign link.clearOffset = clrOut_r;
endmodule
`default_nettype wire

// ---- testbench/prv_link_properties.sv ----
`timescale 1ns/1ns
`default_nettype none
module prv_link_properties
   import prv_pkg::*;
#(
   parameter int SRV_WAIT = 50,
   parameter int CLR_HOLD = 20
)(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic servoOn,
   input wire logic refPulse,
   input wire logic refSign,
   input wire logic clearOffset,
   input wire logic [1:0] cfgForm,
   input wire logic cfgFilter,
   input wire logic signed [ERR_W-1:0] posError,
   input wire logic posLoopEn,
   input wire logic refReady
);
   logic [15:0] srvCnt_r;
   logic [15:0] clrCnt_r;
   logic [15:0] hiCnt_r;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Servo count saturates, so a long run never wraps back under the wait
   always_ff @(posedge clk)
   begin
      srvCnt_r <= (!rst_b || !servoOn) ? 16'h0000 : (srvCnt_r == 16'hffff ? srvCnt_r : srvCnt_r + 16'h0001);
      clrCnt_r <= (!rst_b || !clearOffset) ? 16'h0000 : clrCnt_r + 16'h0001;
      hiCnt_r <= (!rst_b || !refPulse) ? 16'h0000 : hiCnt_r + 16'h0001;
   end
   sequence clrLong;
      clearOffset[*8] ##0 !cfgFilter;
   endsequence
   sequence srvStart;
      $rose(servoOn);
   endsequence
   a_pulse_after_wait:
      assert property ($changed(refPulse) |-> srvCnt_r >= 16'(SRV_WAIT))
         else $error("pulse edge before servo-on wait");
   a_clear_hold:
      assert property ($fell(clearOffset) |-> clrCnt_r >= 16'(CLR_HOLD))
         else $error("clear held too short");
   a_clear_still:
      assert property (clearOffset |-> $stable(refPulse))
         else $error("pulse edge during clear");
   a_clear_zero:
      assert property (clrLong |-> posError == 0 && !posLoopEn)
         else $error("clear did not zero error");
   a_loop_off_wait:
      assert property (srvStart |-> !posLoopEn[*8])
         else $error("loop enabled too early");
   a_ready_needs_srv:
      assert property (!servoOn[*6] |-> !refReady)
         else $error("ready without servo-on");
   a_quad_one_step:
      assert property (cfgForm == PRV_QUAD |-> !($changed(refPulse) && $changed(refSign)))
         else $error("quad double step");
   a_pulse_width:
      assert property ($fell(refPulse) |-> hiCnt_r >= LD_HALF_CYC)
         else $error("pulse high too short");
endmodule
`default_nettype wire

// ---- testbench/test_pulse_train_position_reference.sv ----
`timescale 1ns/1ns
`default_nettype none
module test_pulse_train_position_reference
   import prv_pkg::*;
;
   localparam int SW = 50;
   localparam int CH = 20;
   logic clk = 1'b0;
   logic rst_b;
   logic [3:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [1:0] cfgForm;
   logic [1:0] cfgMult;
   logic cfgFilter;
   logic [GEAR_W-1:0] gearNumIn;
   logic [GEAR_W-1:0] gearDenIn;
   logic fbStep;
   logic fbRev;
   logic signed [ERR_W-1:0] posError;
   logic posLoopEn;
   logic refReady;
   logic [31:0] expErr;
   int miscompares = 0;
   int tests_run = 0;
   prv_link_if link();
   prv_ref_host #(.SRV_WAIT(SW), .CLR_HOLD(CH)) prv_ref_host_inst (.clk(clk), .rst_b(rst_b),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(link));
   prv_ref_dev #(.SRV_WAIT(SW)) prv_ref_dev_inst (.clk(clk), .rst_b(rst_b), .link(link), .cfgForm(cfgForm),
      .cfgMult(cfgMult), .cfgFilter(cfgFilter), .gearNumIn(gearNumIn), .gearDenIn(gearDenIn), .fbStep(fbStep),
      .fbRev(fbRev), .posError(posError), .posLoopEn(posLoopEn), .refReady(refReady));
   prv_link_properties #(.SRV_WAIT(SW), .CLR_HOLD(CH)) prv_link_properties_inst (.clk(clk), .rst_b(rst_b),
      .servoOn(link.servoOn), .refPulse(link.refPulse), .refSign(link.refSign), .clearOffset(link.clearOffset),
      .cfgForm(cfgForm), .cfgFilter(cfgFilter), .posError(posError), .posLoopEn(posLoopEn), .refReady(refReady));
   always #5 clk = ~clk;
   task end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   // Request held until waitrequest is sampled low
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      do
         @(posedge clk);
      while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task rdchk(input logic [3:0] a, input logic [31:0] exp, input string what);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(what, exp, q);
   endtask
   // Settle covers synchroniser, filter window and gear drain
   task poll(input int bitn, input logic val);
      logic [31:0] q;
      do
         bus(1'b0, ADDR_STATUS, 32'h0, q);
      while (q[bitn] !== val);
      repeat (80) @(posedge clk);
   endtask
   // Form switched on the device only once the lines are idle
   task move(input logic [1:0] form, input logic [1:0] mult, input logic dir, input logic oc, input logic [31:0] n,
      input int delta);
      wr(ADDR_CTRL, {26'h0, form, oc, dir, 2'b01});
      repeat (10) @(posedge clk);
      cfgForm <= form;
      cfgMult <= mult;
      cfgFilter <= oc;
      repeat (10) @(posedge clk);
      wr(ADDR_COUNT, n);
      poll(2, 1'b0);
      expErr = expErr + 32'(delta);
      chk("posError", expErr, posError);
   endtask
   initial
   begin
      repeat (50000) @(posedge clk);
      miscompares++;
      end_sim;
   end
   initial
   begin
      {rst_b, avs_address, avs_read, avs_write, avs_writedata, cfgForm, cfgMult, cfgFilter, fbStep, fbRev} = '0;
      gearNumIn = 16'h0001;
      gearDenIn = 16'h0001;
      expErr = 32'h0;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      rdchk(ADDR_CTRL, 32'h0, "ctrl");
      rdchk(ADDR_PERIOD, {16'h0, PERIOD_RST}, "period");
      // Stored as written; the minimum applies to the line timing only
      wr(ADDR_PERIOD, 32'h00000032);
      rdchk(ADDR_PERIOD, 32'h00000032, "period");
      wr(4'h2, 32'hffffffff);
      rdchk(4'h2, 32'h0, "unmapped");
      chk("refReady", 32'h0, {31'h0, refReady});
      wr(ADDR_CTRL, 32'h00000005);
      poll(0, 1'b1);
      chk("posLoopEn", 32'h1, {31'h0, posLoopEn});
      chk("refReady", 32'h1, {31'h0, refReady});
      move(2'h0, 2'h0, 1'b1, 1'b0, 32'h3, 3);
      move(2'h0, 2'h0, 1'b0, 1'b0, 32'h2, -2);
      move(2'h0, 2'h0, 1'b1, 1'b1, 32'h2, 2);
      move(2'h1, 2'h0, 1'b1, 1'b0, 32'h3, 3);
      move(2'h1, 2'h0, 1'b0, 1'b0, 32'h1, -1);
      move(2'h2, 2'h0, 1'b1, 1'b0, 32'h2, 2);
      move(2'h2, 2'h1, 1'b1, 1'b0, 32'h2, 4);
      move(2'h2, 2'h2, 1'b1, 1'b0, 32'h2, 8);
      move(2'h2, 2'h2, 1'b0, 1'b0, 32'h1, -4);
      repeat (3)
      begin
         @(posedge clk);
         fbStep <= 1'b1;
         @(posedge clk);
         fbStep <= 1'b0;
      end
      repeat (10) @(posedge clk);
      chk("posError", expErr - 32'h3, posError);
      wr(ADDR_CTRL, 32'h00000027);
      repeat (12) @(posedge clk);
      chk("posError", 32'h0, posError);
      chk("posLoopEn", 32'h0, {31'h0, posLoopEn});
      poll(1, 1'b0);
      chk("posLoopEn", 32'h1, {31'h0, posLoopEn});
      rdchk(ADDR_CTRL, 32'h00000025, "ctrl");
      // Servo-off must take ready and loop down without a reset
      wr(ADDR_CTRL, 32'h00000000);
      repeat (10) @(posedge clk);
      chk("refReady", 32'h0, {31'h0, refReady});
      chk("posLoopEn", 32'h0, {31'h0, posLoopEn});
      rst_b <= 1'b0;
      cfgForm <= 2'h0;
      gearNumIn <= 16'h0003;
      gearDenIn <= 16'h0002;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      // Late change must be ignored until the next reboot
      gearNumIn <= 16'h0007;
      expErr = 32'h0;
      wr(ADDR_CTRL, 32'h00000005);
      poll(0, 1'b1);
      move(2'h0, 2'h0, 1'b1, 1'b0, 32'h4, 6);
      end_sim;
   end
endmodule
`default_nettype wire
